// file: verilog/eeprom_access_defines.vh
// Constants for the data EEPROM access control block.
// Assumes inclusion by bare name from the design files.
`ifndef EEPROM_ACCESS_DEFINES_VH
`define EEPROM_ACCESS_DEFINES_VH
`define NV_CTRL_ADDR 8'hd2
`define NV_KEY_HI 7
`define NV_KEY_LO 4
`define NV_MAP_BIT 1
`define NV_BUSY_BIT 0
`define NV_KEY_FIRST 4'h5
`define NV_KEY_SECOND 4'ha
`define NV_MAP_VALUE 8'h02
`define NV_PAGE_BYTES 128
`define NV_PAGE_AW 7
`define NV_ADDR_W 11
`define NV_PROG_TIME_US 10
`define NV_PROG_CYCLES (`NV_PROG_TIME_US * 1000 / 10)
`endif

// file: verilog/column_latch_page.v
// Page buffer of column latches with per-byte load flags.
// Assumes a single clock, clear pulse after programming.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_defines.vh"
module column_latch_page (
  // Clock and reset
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  // Load side
  input wire load,
  input wire [`NV_PAGE_AW-1:0] load_index,
  input wire [7:0] load_data,
  input wire clear,
  // Read side for the programming engine
  input wire [`NV_PAGE_AW-1:0] rd_index,
  output wire [7:0] rd_data,
  output wire rd_loaded
);
  reg [7:0] mem_q [0:`NV_PAGE_BYTES-1];
  reg [`NV_PAGE_BYTES-1:0] loaded_q;
  integer i;

  // Storage; any count of loads up to a page (RULE7)
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      loaded_q <= {`NV_PAGE_BYTES{1'b0}};
      for (i = 0; i < `NV_PAGE_BYTES; i = i + 1)
        mem_q[i] <= 8'h00;
    end
    else if (clk_en)
    begin
      if (clear)
        loaded_q <= {`NV_PAGE_BYTES{1'b0}};
      // Load in the clear cycle still counts: set beats clear
      if (load)
      begin
        mem_q[load_index] <= load_data; // RULE7
        loaded_q[load_index] <= 1'b1;
      end
    end
  end

  assign rd_data = mem_q[rd_index];
  assign rd_loaded = loaded_q[rd_index];
endmodule // column_latch_page
`default_nettype wire

// file: verilog/eeprom_access_control.v
// Control register and MOVX steering for the on-chip data EEPROM.
// Assumes CPU SFR bus and MOVX bus on mclk; array model sits outside.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_defines.vh"
// Summary of operation
// (RULE1) The control register decodes at SFR 0D2h: key bits 7-4, map bit 1, busy bit 0.
// (RULE2) Reset clears map and busy; only whole-byte writes are accepted.
// (RULE3) Writing 02h maps MOVX reads to the array and MOVX writes to the latches.
// (RULE4) Software writes 00h after each access to unmap the array.
// (RULE5) Software checks busy is clear and masks interrupts around accesses.
// (RULE6) Bits 3 and 2 are reserved, read as zero here, and must be written as zero.
// (RULE7) The latches take one to 128 byte loads before a launch.
// (RULE8) Writing key 5 then key A launches programming of the loaded page.
// (RULE9) Any instruction between the two key writes aborts the launch.
// (RULE10) Busy is set by hardware at launch, blocks reads, clears at completion.
module eeprom_access_control #(
  parameter PROG_CYCLES = `NV_PROG_CYCLES
) (
  // Clock, reset, enable
  input wire mclk,
  input wire reset_n,
  input wire clk_en,
  // SFR bus
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_bit_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  // Instruction boundary strobe
  input wire instr_done,
  // MOVX bus
  input wire [15:0] movx_addr,
  input wire movx_rd,
  input wire movx_wr,
  input wire [7:0] movx_wdata,
  output reg movx_claim,
  output reg [7:0] movx_rdata,
  // EEPROM array
  output reg [`NV_ADDR_W-1:0] array_addr,
  output reg array_rd,
  input wire [7:0] array_rdata,
  output reg array_wr,
  output reg [7:0] array_wdata
);
  localparam ST_IDLE = 2'd0;
  localparam ST_PROG = 2'd1;
  localparam ST_WAIT = 2'd2;

  reg [3:0] key_q;
  reg map_q;
  reg busy_q;
  reg armed_q;
  reg [1:0] state_q;
  reg [`NV_PAGE_AW-1:0] idx_q;
  reg [`NV_ADDR_W-`NV_PAGE_AW-1:0] page_q;
  reg [19:0] wait_q;
  reg clear_q;
  wire [7:0] cl_data;
  wire cl_loaded;
  wire ctrl_hit;
  wire ctrl_wr;
  wire launch;
  wire mapped_ld;

  // Byte writes only; bit-instruction writes are ignored
  assign ctrl_hit = (sfr_addr == `NV_CTRL_ADDR); // RULE1
  assign ctrl_wr = ctrl_hit && sfr_wr && !sfr_bit_wr; // RULE2
  assign launch = ctrl_wr && armed_q && !busy_q &&
    (sfr_wdata[`NV_KEY_HI:`NV_KEY_LO] == `NV_KEY_SECOND); // RULE8
  assign mapped_ld = map_q && movx_wr && !busy_q;

  column_latch_page u_latch (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .load(mapped_ld),
    .load_index(movx_addr[`NV_PAGE_AW-1:0]),
    .load_data(movx_wdata),
    .clear(clear_q),
    .rd_index(idx_q),
    .rd_data(cl_data),
    .rd_loaded(cl_loaded)
  );

  // Control register and key sequencing
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      key_q <= 4'h0;
      map_q <= 1'b0; // RULE2
      armed_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (ctrl_wr)
      begin
        key_q <= sfr_wdata[`NV_KEY_HI:`NV_KEY_LO];
        map_q <= sfr_wdata[`NV_MAP_BIT]; // RULE3
        armed_q <= (sfr_wdata[`NV_KEY_HI:`NV_KEY_LO] == `NV_KEY_FIRST);
      end
      else if (instr_done)
        armed_q <= 1'b0; // RULE9
    end
  end

  // Page address follows the last latch load
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      page_q <= {(`NV_ADDR_W-`NV_PAGE_AW){1'b0}};
    else if (clk_en && mapped_ld)
      page_q <= movx_addr[`NV_ADDR_W-1:`NV_PAGE_AW];
  end

  // Programming engine: copy loaded bytes, then wait the cell time
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
      idx_q <= {`NV_PAGE_AW{1'b0}};
      wait_q <= 20'h0_0000;
      clear_q <= 1'b0;
      array_wr <= 1'b0;
      array_wdata <= 8'h00;
    end
    else if (clk_en)
    begin
      clear_q <= 1'b0;
      array_wr <= 1'b0;
      case (state_q)
        ST_IDLE:
        begin
          if (launch)
          begin
            busy_q <= 1'b1; // RULE10
            idx_q <= {`NV_PAGE_AW{1'b0}};
            state_q <= ST_PROG;
          end
        end
        ST_PROG:
        begin
          array_wr <= cl_loaded;
          array_wdata <= cl_data;
          if (idx_q == `NV_PAGE_BYTES - 1)
          begin
            wait_q <= PROG_CYCLES[19:0];
            state_q <= ST_WAIT;
          end
          else
            idx_q <= idx_q + 1'b1;
        end
        ST_WAIT:
        begin
          if (wait_q <= 20'h0_0001)
          begin
            busy_q <= 1'b0; // RULE10
            clear_q <= 1'b1;
            state_q <= ST_IDLE;
          end
          else
            wait_q <= wait_q - 20'h0_0001;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  // Array address and read steering; reads blocked while busy
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      array_addr <= {`NV_ADDR_W{1'b0}};
      array_rd <= 1'b0;
      movx_claim <= 1'b0;
    end
    else if (clk_en)
    begin
      array_rd <= map_q && movx_rd && !busy_q; // RULE10
      movx_claim <= map_q && (movx_rd || movx_wr); // RULE3
      if (state_q == ST_PROG)
        array_addr <= {page_q, idx_q};
      else
        array_addr <= movx_addr[`NV_ADDR_W-1:0];
    end
  end

  // Read data back to CPU; reserved bits read zero
  always @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sfr_rdata <= 8'h00;
      movx_rdata <= 8'h00;
    end
    else if (clk_en)
    begin
      if (ctrl_hit && sfr_rd)
        sfr_rdata <= {key_q, 2'b00, map_q, busy_q}; // RULE6
      else
        sfr_rdata <= 8'h00;
      movx_rdata <= array_rd ? array_rdata : 8'h00;
    end
  end
endmodule // eeprom_access_control
`default_nettype wire

// file: sim/eeprom_access_control_properties.sv
// Checker for the data EEPROM access control block.
// Assumes it is bound to the block's ports by name.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_defines.vh"
module eeprom_access_props (
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  // SFR bus
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_bit_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic instr_done,
  // MOVX bus
  input wire logic [15:0] movx_addr,
  input wire logic movx_rd,
  input wire logic movx_wr,
  input wire logic [7:0] movx_wdata,
  input wire logic movx_claim,
  input wire logic [7:0] movx_rdata,
  // EEPROM array
  input wire logic [`NV_ADDR_W-1:0] array_addr,
  input wire logic array_rd,
  input wire logic [7:0] array_rdata,
  input wire logic array_wr,
  input wire logic [7:0] array_wdata
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Byte write, read and MOVX strobes as the block takes them
  wire w = clk_en && sfr_wr && !sfr_bit_wr && sfr_addr == 8'hd2;
  wire r = clk_en && sfr_rd && sfr_addr == 8'hd2;
  wire m = clk_en && (movx_rd || movx_wr);
  property p_res; r |=> sfr_rdata[3:2] == 2'b00; endproperty
  a_res: assert property (p_res) else $error("reserved bits set");
  property p_key;
    w && sfr_wdata == 8'h50 ##1 w && sfr_wdata == 8'ha0 && !instr_done
    ##[1:2] r |=> sfr_rdata[0];
  endproperty
  a_key: assert property (p_key) else $error("no busy");
  property p_blk;
    w && sfr_wdata == 8'h50 ##1 w && sfr_wdata == 8'ha0 && !instr_done
    ##[1:8] (clk_en && movx_rd) |=> !array_rd;
  endproperty
  a_blk: assert property (p_blk) else $error("read in busy");
  // Unmapped accesses, even after a bit write, are never claimed
  property p_unm;
    w && sfr_wdata == 8'h00 ##1 !w ##1 m |=> !movx_claim;
  endproperty
  a_unm: assert property (p_unm) else $error("claim unmapped");
  property p_bit;
    w && sfr_wdata == 8'h00 ##1 !w [*3]
    ##1 (clk_en && sfr_wr && sfr_bit_wr && sfr_addr == 8'hd2 && sfr_wdata[1])
    ##1 !w ##1 m |=> !movx_claim;
  endproperty
  a_bit: assert property (p_bit) else $error("bit write took");
  // A frozen claim under a low enable is not a new one
  property p_clm; movx_claim && $past(clk_en) |-> $past(m); endproperty
  a_clm: assert property (p_clm) else $error("stray claim");
  property p_rdd;
    clk_en && array_rd |=> movx_rdata == $past(array_rdata);
  endproperty
  a_rdd: assert property (p_rdd) else $error("read data lost");
  property p_rst;
    $rose(reset_n) |-> !movx_claim && !array_wr && !array_rd;
  endproperty
  a_rst: assert property (p_rst) else $error("active at reset");
  c_launch: cover property (w && sfr_wdata == 8'ha0);
  c_prog: cover property (array_wr);
  c_read: cover property (array_rd);
endmodule // eeprom_access_props
bind eeprom_access_control eeprom_access_props u_props (.*);
`default_nettype wire

// file: sim/eeprom_access_control_tb.sv
// Bench for the data EEPROM access control block.
// Assumes the block alone; array read data is held constant.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_access_defines.vh"
module eeprom_access_control_tb;
  reg mclk = 0, reset_n = 0, sfr_wr = 0, sfr_bit_wr = 0, sfr_rd = 0;
  reg instr_done = 0, movx_rd = 0, movx_wr = 0;
  reg [7:0] sfr_addr = 0, sfr_wdata = 0, movx_wdata = 0, v;
  reg [15:0] movx_addr = 0;
  reg clk_en = 1'b1;
  wire [7:0] array_rdata = 8'h3c;
  wire [7:0] sfr_rdata, movx_rdata, array_wdata;
  wire [`NV_ADDR_W-1:0] array_addr;
  wire movx_claim, array_rd, array_wr;
  integer num_errors = 0, check_count = 0, n_wr = 0, n_clm = 0, i;
  always #5 mclk = ~mclk;
  // Short programming time keeps the run brief
  eeprom_access_control #(.PROG_CYCLES(4)) DUT (.*);
  task chk(input [39:0] s, e);
  begin
    check_count = check_count + 1;
    if (s !== e)
    begin
      num_errors = num_errors + 1;
      $display("BAD %0t %h %h", $time, s, e);
    end
  end
  endtask
  task cyc;
  begin
    @(posedge mclk);
    #1;
  end
  endtask
  task sw(input b, input [7:0] d);
  begin
    sfr_wr = 1;
    sfr_bit_wr = b;
    sfr_addr = 8'hd2;
    sfr_wdata = d;
    cyc;
    sfr_wr = 0;
    sfr_bit_wr = 0;
    cyc;
  end
  endtask
  // Key pair; gap puts another instruction between
  task key(input gap);
  begin
    sfr_wr = 1;
    sfr_wdata = 8'h50;
    cyc;
    if (gap)
    begin
      sfr_wr = 0;
      instr_done = 1;
      cyc;
      instr_done = 0;
      sfr_wr = 1;
    end
    sfr_wdata = 8'ha0;
    cyc;
    sfr_wr = 0;
    cyc;
  end
  endtask
  task sr;
  begin
    sfr_rd = 1;
    cyc;
    sfr_rd = 0;
    v = sfr_rdata;
    cyc;
  end
  endtask
  task mx(input w, input [15:0] a, input [7:0] d);
  begin
    movx_wr = w;
    movx_rd = !w;
    movx_addr = a;
    movx_wdata = d;
    cyc;
    movx_rd = 0;
    movx_wr = 0;
    cyc;
  end
  endtask
  // Count claims and check each programmed byte lands on page 3
  always @(posedge mclk)
  begin
    if (movx_claim)
      n_clm = n_clm + 1;
    if (array_wr)
    begin
      chk({array_addr, array_wdata}, {4'h3, n_wr[6:0], 1'b0, n_wr[6:0]});
      n_wr = n_wr + 1;
    end
  end
  task t_map;
  begin
    sr;
    chk(v[3:0], 4'h0);
    sw(0, 8'h02);
    sr;
    chk(v[1:0], 2'b10);
    mx(0, 16'h0123, 0);
    chk({n_clm, movx_rdata}, {32'd1, 8'h3c});
    sw(0, 8'h00);
    mx(0, 16'h0123, 0);
    sw(1, 8'h02);
    mx(1, 16'h0123, 0);
    chk(n_clm, 1);
    $display("map test done");
  end
  endtask
  // Enable low: a write in that span must not take
  task t_hold;
  begin
    clk_en = 0;
    sw(0, 8'h02);
    clk_en = 1;
    sr;
    chk(v[1], 1'b0);
    $display("hold test done");
  end
  endtask
  task t_prog;
  begin
    sw(0, 8'h02);
    for (i = 0; i < 128; i = i + 1)
      mx(1, 16'h0180 + i, i);
    sw(0, 8'h00);
    key(0);
    sr;
    chk(v[0], 1);
    // Deliberate breach of the busy check: the read must be refused
    sw(0, 8'h02);
    mx(0, 16'h0180, 0);
    chk(movx_rdata, 8'h00);
    sw(0, 8'h00);
    for (i = 0; i < 400 && v[0]; i = i + 1)
      sr;
    chk({n_wr, v[0]}, {32'd128, 1'b0});
    $display("program test done");
  end
  endtask
  task t_abort;
  begin
    sw(0, 8'h02);
    mx(1, 16'h0180, 0);
    sw(0, 8'h00);
    key(1);
    sr;
    repeat (150) cyc;
    chk({n_wr, v[0]}, {32'd128, 1'b0});
    $display("abort test done");
  end
  endtask
  task give_verdict;
  begin
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    #1 reset_n = 1;
    cyc;
    t_map;
    t_hold;
    t_prog;
    t_abort;
    give_verdict;
  end
  // Watchdog well past the expected run
  initial
  begin
    #50000;
    num_errors = num_errors + 1;
    give_verdict;
  end
endmodule // eeprom_access_control_tb
`default_nettype wire
